/* File: core/uif_irq.v */
/*
 * USB interrupt flags and enables with AXI4-Lite register access.
 * Holds the flag register (sticky but for the live error summary bit), its enable register, the role select,
 * the per-error enables that feed the error summary and a small token
 * status queue whose head software reads after a token completes.
 * Assumes: event inputs are one-cycle strobes synchronous to core_clk from
 * the transaction engine; line state inputs are synchronous levels.
 * Assumes the engine does not complete tokens faster than software pops
 * them; an entry beyond the queue depth is lost.
 */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.

// How it works
// - Host role: received stall sets stall flag
// - Peripheral role: sent stall sets stall flag
// - Peripheral connection sets attach flag
// - Attach valid: host, 2.5 us quiet, not SE0
// - K state for 2.5 us sets resume
// - Idle bus for 3 ms sets idle
// - Token end sets flag, status shows endpoint
// - Clearing token flag advances status FIFO
// - SOF received or host threshold sets flag
// - Only enabled errors set error summary
// - Peripheral role: bit 0 is bus reset
// - Host role: bit 0 is detach
// - Eight enable bits, reset zero, per flag
// - Flag bits 31 to 8 read zero
// - Write one clears; error summary read only
// - Error reaches irq only when enabled

`timescale 1ns/1ps
`include "uif_map.vh"

module uif_irq #(
   parameter QUIET_CYC = `UIF_QUIET_CYC,
   parameter IDLE_CYC = `UIF_IDLE_CYC,
   parameter ERR_W = 8
)(
   input wire core_clk,
   input wire rst_n,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Event strobes from the transaction engine
   input wire stall_rx_stb,
   input wire stall_tx_stb,
   input wire attach_stb,
   input wire detach_stb,
   input wire usb_reset_stb,
   input wire sof_rx_stb,
   input wire sof_thresh_stb,
   input wire [ERR_W-1:0] err_event,
   input wire token_done_stb,
   input wire [7:0] token_info,
   // Line state levels
   input wire bus_activity,
   input wire line_se0,
   input wire line_k,
   input wire line_idle,
   // Outputs
   output wire host_role_enable,
   output wire combined_usb_irq
);

   localparam TOK_DEPTH = 4;
   localparam QW = 12;
   localparam IW = 20;

   // Register state
   reg [7:0] flags_q; // Interrupt flags; sticky except the live error summary bit
   reg [7:0] flags_d;
   reg [7:0] enables_q; // Per-flag enables
   reg host_q; // Host role select
   reg [ERR_W-1:0] err_en_q; // Per-error enables feeding the summary
   reg [QW-1:0] quiet_cnt_q; // Cycles without bus activity
   reg [QW-1:0] k_cnt_q; // Cycles of continuous K state
   reg [IW-1:0] idle_cnt_q; // Cycles of continuous idle
   reg k_done_q; // Resume already reported for this K period
   reg idle_done_q; // Idle already reported for this idle period
   // Token status FIFO
   reg [7:0] tok_mem [0:TOK_DEPTH-1];
   reg [1:0] tok_wp_q;
   reg [1:0] tok_rp_q;
   reg [2:0] tok_cnt_q;

   // Bus handshake state
   reg aw_hold_q; // Write address captured
   reg w_hold_q; // Write data captured
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   // Role select also steers which strobe feeds stall, frame start and bit 0
   assign host_role_enable = host_q;

   // Ready while nothing held and no response pending
   assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire aw_now = aw_hold_q | (s_axi_awvalid & s_axi_awready);
   wire w_now = w_hold_q | (s_axi_wvalid & s_axi_wready);
   wire [7:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
   wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
   // Write commits when both halves are present
   wire wr_go = aw_now & w_now & ~s_axi_bvalid;
   wire wr_lane0 = wr_go & wr_strb[0];
   wire wr_flags = wr_lane0 & (wr_addr == `UIF_FLAGS_OFS);
   wire wr_map = (wr_addr == `UIF_FLAGS_OFS) | (wr_addr == `UIF_ENABLES_OFS) |
      (wr_addr == `UIF_CTRL_OFS) | (wr_addr == `UIF_ERREN_OFS) |
      (wr_addr == `UIF_TOKSTAT_OFS);

   // Write-one-to-clear mask; error summary is read only
   // clear mask
   wire [7:0] clr_mask = wr_flags ?
      (wr_data[7:0] & ~(8'h01 << `UIF_BIT_ERR)) : 8'h00;

   wire quiet_ok = (quiet_cnt_q >= QUIET_CYC[QW-1:0]);
   wire attach_ok = host_q & quiet_ok & ~line_se0;
   wire err_hit = |(err_event & err_en_q);
   wire tok_empty = (tok_cnt_q == 3'd0);

   // Hardware set events, one bit per flag
   reg [7:0] set_vec;
   always @*
   begin
      set_vec = 8'h00;
      set_vec[`UIF_BIT_STALL] = (host_q & stall_rx_stb) | (~host_q & stall_tx_stb);
      set_vec[`UIF_BIT_ATTACH] = attach_stb & attach_ok;
      set_vec[`UIF_BIT_RESUME] = line_k & ~k_done_q & (k_cnt_q >= QUIET_CYC[QW-1:0]);
      set_vec[`UIF_BIT_IDLE] = line_idle & ~idle_done_q & (idle_cnt_q >= IDLE_CYC[IW-1:0]);
      set_vec[`UIF_BIT_TOKEN] = token_done_stb;
      set_vec[`UIF_BIT_SOF] = (host_q & sof_thresh_stb) | (~host_q & sof_rx_stb);
      set_vec[`UIF_BIT_ERR] = err_hit;
      set_vec[`UIF_BIT_RST] = (host_q & detach_stb) | (~host_q & usb_reset_stb);
   end

   // Next flags; a set in the clear cycle wins so no event is lost
   always @*
   begin
      flags_d = (flags_q & ~clr_mask) | set_vec;
      // Token flag stays up while entries remain queued after a pop
      if (clr_mask[`UIF_BIT_TOKEN] & (tok_cnt_q > 3'd1))
      begin
         flags_d[`UIF_BIT_TOKEN] = 1'b1;
      end
   end

   // Error summary follows live errors: no software clear exists for it
   wire err_level = err_hit;

   // Flag, enable and control registers
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         flags_q <= `UIF_FLAGS_RST;
         enables_q <= `UIF_ENABLES_RST;
         host_q <= 1'b0;
         err_en_q <= {ERR_W{1'b0}};
      end
      else
      begin
         flags_q <= {flags_d[7:2], err_level, flags_d[0]};
         if (wr_lane0 && wr_addr == `UIF_ENABLES_OFS)
         begin
            enables_q <= wr_data[7:0];
         end
         if (wr_lane0 && wr_addr == `UIF_CTRL_OFS)
         begin
            host_q <= wr_data[`UIF_CTRL_HOST];
         end
         if (wr_lane0 && wr_addr == `UIF_ERREN_OFS)
         begin
            err_en_q <= wr_data[ERR_W-1:0];
         end
      end
   end

   // Line timers saturate; the done flags make each flag fire once per period
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         quiet_cnt_q <= {QW{1'b0}};
         k_cnt_q <= {QW{1'b0}};
         idle_cnt_q <= {IW{1'b0}};
         k_done_q <= 1'b0;
         idle_done_q <= 1'b0;
      end
      else
      begin
         if (bus_activity)
            quiet_cnt_q <= {QW{1'b0}};
         else if (!quiet_ok)
            quiet_cnt_q <= quiet_cnt_q + 1'b1;
         if (!line_k)
         begin
            k_cnt_q <= {QW{1'b0}};
            k_done_q <= 1'b0;
         end
         else
         begin
            if (k_cnt_q < QUIET_CYC[QW-1:0])
               k_cnt_q <= k_cnt_q + 1'b1;
            if (set_vec[`UIF_BIT_RESUME])
               k_done_q <= 1'b1;
         end
         if (!line_idle)
         begin
            idle_cnt_q <= {IW{1'b0}};
            idle_done_q <= 1'b0;
         end
         else
         begin
            if (idle_cnt_q < IDLE_CYC[IW-1:0])
               idle_cnt_q <= idle_cnt_q + 1'b1;
            if (set_vec[`UIF_BIT_IDLE])
               idle_done_q <= 1'b1;
         end
      end
   end

   // Token status FIFO: push on completion, pop when the flag is cleared
   // pop on clear
   wire tok_pop = clr_mask[`UIF_BIT_TOKEN] & flags_q[`UIF_BIT_TOKEN] & ~tok_empty;
   // A full FIFO drops the newest entry; the engine should not outrun software
   wire tok_push = token_done_stb & ((tok_cnt_q != TOK_DEPTH[2:0]) | tok_pop);
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         tok_wp_q <= 2'd0;
         tok_rp_q <= 2'd0;
         tok_cnt_q <= 3'd0;
      end
      else
      begin
         if (tok_push)
         begin
            tok_mem[tok_wp_q] <= token_info;
            tok_wp_q <= tok_wp_q + 2'd1;
         end
         if (tok_pop)
            tok_rp_q <= tok_rp_q + 2'd1;
         if (tok_push & ~tok_pop)
            tok_cnt_q <= tok_cnt_q + 3'd1;
         else if (tok_pop & ~tok_push)
            tok_cnt_q <= tok_cnt_q - 3'd1;
      end
   end

   // Write channel capture and response
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `UIF_RESP_OKAY;
      end
      else
      begin
         if (wr_go)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Unmapped address answers with a slave error
            s_axi_bresp <= wr_map ? `UIF_RESP_OKAY : `UIF_RESP_SLVERR;
         end
         else
         begin
            if (s_axi_awvalid & s_axi_awready)
            begin
               aw_hold_q <= 1'b1;
               aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
               w_hold_q <= 1'b1;
               w_data_q <= s_axi_wdata;
               w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data mux; upper bits read zero
   reg [31:0] rd_mux;
   reg rd_ok;
   always @*
   begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `UIF_FLAGS_OFS: rd_mux[7:0] = flags_q;
         `UIF_ENABLES_OFS: rd_mux[7:0] = enables_q;
         `UIF_CTRL_OFS: rd_mux[0] = host_q;
         `UIF_ERREN_OFS: rd_mux[ERR_W-1:0] = err_en_q;
         `UIF_TOKSTAT_OFS: rd_mux[7:0] = tok_empty ? 8'h00 : tok_mem[tok_rp_q];
         default: rd_ok = 1'b0;
      endcase
   end

   // Read response, one cycle after the address is taken
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `UIF_RESP_OKAY;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? `UIF_RESP_OKAY : `UIF_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Combined request; error bit passes only through its enable
   // error gated by enable
   assign combined_usb_irq = |(flags_q & enables_q);

endmodule // uif_irq

/* File: core/uif_map.vh */
/*
 * Register map, field positions, reset values and timing figures of the USB
 * interrupt flag and enable block.
 * Assumes a 250 MHz core clock and 32-bit AXI4-Lite register access.
 */
`ifndef UIF_MAP_VH
`define UIF_MAP_VH

// Byte offsets of the registers
`define UIF_FLAGS_OFS 8'h00
`define UIF_ENABLES_OFS 8'h04
`define UIF_CTRL_OFS 8'h08
`define UIF_ERREN_OFS 8'h0C
`define UIF_TOKSTAT_OFS 8'h10

// Flag and enable bit positions
`define UIF_BIT_STALL 7
`define UIF_BIT_ATTACH 6
`define UIF_BIT_RESUME 5
`define UIF_BIT_IDLE 4
`define UIF_BIT_TOKEN 3
`define UIF_BIT_SOF 2
`define UIF_BIT_ERR 1
`define UIF_BIT_RST 0

// Control register field: host role enable
`define UIF_CTRL_HOST 0

// Reset values
`define UIF_FLAGS_RST 8'h00
`define UIF_ENABLES_RST 8'h00

// Timing figures in ns and their cycle counts at 4 ns per cycle
`define UIF_CLK_NS 4
`define UIF_QUIET_NS 2500
`define UIF_QUIET_CYC (`UIF_QUIET_NS / `UIF_CLK_NS)
`define UIF_IDLE_NS 3000000
`define UIF_IDLE_CYC (`UIF_IDLE_NS / `UIF_CLK_NS)

// AXI response codes
`define UIF_RESP_OKAY 2'b00
`define UIF_RESP_SLVERR 2'b10

`endif

/* File: tb/uif_irq_checker.sv */
/* Checker for uif_irq: bus handshakes, read data shape and irq causes.
   Assumes it is bound to uif_irq and sees only its ports. */
`timescale 1ns/1ps
`include "uif_map.vh"
module uif_irq_checker (
   input wire core_clk,
   input wire rst_n,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire [7:0] err_event,
   input wire combined_usb_irq
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
   a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `UIF_RESP_SLVERR
      |-> s_axi_rdata == 32'h00000000) else $error("error read carries data");
   // Irq only drops after a write half was taken or after errors went away;
   // a write commits at whichever half arrives last
   a_irq_fall: assert property ($fell(combined_usb_irq) |->
      $past((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready))
      || $past(|err_event, 2)) else $error("irq dropped by itself");
   // Reset must clear answers and irq whatever came before
   a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0) !rst_n
      |=> !s_axi_bvalid && !s_axi_rvalid && !combined_usb_irq) else $error("reset not quiet");
   c_write: cover property (s_axi_bvalid);
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `UIF_RESP_SLVERR);
   c_irq: cover property ($rose(combined_usb_irq));
endmodule // uif_irq_checker
bind uif_irq uif_irq_checker chk_u (
   .core_clk(core_clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .err_event(err_event), .combined_usb_irq(combined_usb_irq)
);

/* File: tb/uif_peer.sv */
/* USB side peer: pulses engine event strobes and holds line states.
   Assumes callers enter its tasks just after a rising clock edge. */
`timescale 1ns/1ps
module uif_peer (
   input wire core_clk
);
   // Event strobes, one bit per event kind
   logic [7:0] stb = 8'h00;
   // Endpoint info shown with a token strobe
   logic [7:0] info = 8'h00;
   // Line levels: 0 K, 1 idle, 2 activity, 3 SE0
   logic [3:0] line = 4'h0;
   // One-cycle strobe; the spare cycle avoids two writes in one step
   task pulse(input int i, input logic [7:0] d);
      stb[i] <= 1'b1;
      info <= d;
      @(posedge core_clk);
      stb <= 8'h00;
      @(posedge core_clk);
   endtask
   // Hold one line level for n cycles, then release it
   task hold(input int i, input int n);
      line[i] <= 1'b1;
      repeat (n) @(posedge core_clk);
      line <= 4'h0;
      @(posedge core_clk);
   endtask
endmodule // uif_peer

/* File: tb/test_usb_interrupt_flags_enables.sv */
/* Testbench for uif_irq: register tasks and event scenarios.
   Assumes uif_peer stands in for the USB engine side. */
`timescale 1ns/1ps
`include "uif_map.vh"
module test_usb_interrupt_flags_enables;
   // Short counts keep the run brief
   localparam QC = 8;
   localparam IC = 40;
   localparam [7:0] FL = `UIF_FLAGS_OFS;
   localparam [7:0] EN = `UIF_ENABLES_OFS;
   localparam [7:0] CT = `UIF_CTRL_OFS;
   localparam [7:0] EE = `UIF_ERREN_OFS;
   localparam [7:0] TS = `UIF_TOKSTAT_OFS;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, err_event = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   // Responses are always accepted at once
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire host_role_enable, combined_usb_irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int bad_count = 0, checked = 0;
   uif_peer peer_u (.core_clk(core_clk));
   wire [7:0] stb = peer_u.stb;
   wire [7:0] info = peer_u.info;
   wire [3:0] line = peer_u.line;
   uif_irq #(.QUIET_CYC(QC), .IDLE_CYC(IC), .ERR_W(8)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .err_event(err_event), .host_role_enable(host_role_enable),
      .combined_usb_irq(combined_usb_irq),
      .stall_rx_stb(stb[0]),
      .stall_tx_stb(stb[1]),
      .attach_stb(stb[2]),
      .detach_stb(stb[3]),
      .usb_reset_stb(stb[4]),
      .sof_rx_stb(stb[5]),
      .sof_thresh_stb(stb[6]),
      .token_done_stb(stb[7]),
      .token_info(info),
      .line_k(line[0]),
      .line_idle(line[1]),
      .bus_activity(line[2]),
      .line_se0(line[3])
   );
   always #2 core_clk = ~core_clk;
   task end_sim;
      $display("checks=%0d mismatches=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Address and data offered together, each released once taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, r);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   // Fire each strobe named in a mask
   task ev(input logic [7:0] m);
      for (int i = 0; i < 8; i++) if (m[i]) peer_u.pulse(i, 8'h00);
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      end_sim;
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(FL, 0);
      rd(EN, 0);
      rd(8'h14, 0, `UIF_RESP_SLVERR);
      wr(8'h14, 32'hFF, `UIF_RESP_SLVERR);
      wr(EN, 32'hFFFFFFFF);
      rd(EN, 32'h000000FF);
      // Host-role strobes are ignored in the peripheral role
      wr(EN, 32'h85);
      ev(8'h4D);
      rd(FL, 0);
      chk(combined_usb_irq, 0);
      ev(8'h32);
      rd(FL, 32'h85);
      chk(combined_usb_irq, 1);
      wr(EN, 0);
      chk(combined_usb_irq, 0);
      wr(EN, 32'h85);
      wr(FL, 32'h81);
      rd(FL, 32'h04);
      chk(combined_usb_irq, 1);
      wr(FL, 32'h04);
      chk(combined_usb_irq, 0);
      wr(CT, 1);
      chk(host_role_enable, 1);
      ev(8'h32);
      rd(FL, 0);
      ev(8'h49);
      rd(FL, 32'h85);
      wr(FL, 32'hFF);
      peer_u.hold(2, 2);
      peer_u.pulse(2, 8'h00);
      rd(FL, 0);
      repeat (QC + 2) @(posedge core_clk);
      peer_u.pulse(2, 8'h00);
      rd(FL, 32'h40);
      wr(FL, 32'hFF);
      // Attach while the line shows SE0 must be ignored
      fork
         peer_u.hold(3, 6);
         begin
            @(posedge core_clk);
            peer_u.pulse(2, 8'h00);
         end
      join
      rd(FL, 0);
      peer_u.hold(0, QC - 2);
      rd(FL, 0);
      peer_u.hold(0, QC + 2);
      rd(FL, 32'h20);
      peer_u.hold(1, IC + 2);
      rd(FL, 32'h30);
      wr(FL, 32'hFF);
      peer_u.pulse(7, 8'h11);
      peer_u.pulse(7, 8'h22);
      rd(FL, 32'h08);
      rd(TS, 32'h11);
      wr(FL, 32'h08);
      rd(FL, 32'h08);
      rd(TS, 32'h22);
      wr(FL, 32'h08);
      rd(FL, 0);
      rd(TS, 0);
      err_event <= 8'h01;
      rd(FL, 0);
      wr(EE, 1);
      rd(FL, 32'h02);
      wr(FL, 32'h02);
      rd(FL, 32'h02);
      chk(combined_usb_irq, 0);
      wr(EN, 32'h02);
      chk(combined_usb_irq, 1);
      err_event <= 8'h00;
      repeat (3) @(posedge core_clk);
      rd(FL, 0);
      chk(combined_usb_irq, 0);
      end_sim;
   end
endmodule // test_usb_interrupt_flags_enables
